/* design/act_pkg.sv */
// Constants and types for the converter timing and channel selection logic.
// Assumes a single 25 MHz system clock; converter clock is an enable input.
package act_pkg;
	localparam int ACT_INIT_SAMPLE_CYC = 2;
	localparam int ACT_FINAL_MIN_CYC = 2;
	localparam int ACT_RES_BITS = 10;
	localparam logic [5:0] ACT_CH_REF_LO = 6'h3C;
	localparam logic [5:0] ACT_CH_REF_HI = 6'h3D;
	localparam logic [5:0] ACT_CH_MID = 6'h3E;
	localparam logic [5:0] ACT_CH_EOQ = 6'h3F;
	localparam logic [5:0] ACT_CH_ADR0 = 6'h34;
	localparam logic [5:0] ACT_CH_ADR1 = 6'h35;
	localparam logic [5:0] ACT_CH_AN55 = 6'h37;
	localparam logic [5:0] ACT_CH_AN56 = 6'h38;
	localparam logic [3:0] ACT_PIN_NONE = 4'hF;
	localparam logic [3:0] ACT_PIN_AN55 = 4'h6;
	localparam logic [3:0] ACT_PIN_AN56 = 4'h7;
	localparam logic [3:0] ACT_PIN_ADR0 = 4'h4;
	localparam logic [3:0] ACT_PIN_ADR1 = 4'h5;

	typedef enum logic [1:0]
	{
		ACT_REF_NONE,
		ACT_REF_LOW,
		ACT_REF_HIGH,
		ACT_REF_MID
	} act_ref_t;

	// One command entry as presented by queue control
	typedef struct packed
	{
		logic [5:0] chan;
		logic [1:0] final_sample_sel;
		logic buffer_skip_flag;
	} act_cmd_t;

	// Analog front end selection
	typedef struct packed
	{
		logic [3:0] pin;
		act_ref_t ref_sel;
		logic [1:0] ext_mux_addr_out;
		logic valid;
	} act_sel_t;
endpackage

/* design/act_chan_decode.sv */
// Channel decoder: command channel number to pin, reference and mux address.
// Assumes mux mode bit comes straight from the first control register.
`timescale 1ns/100ps
module act_chan_decode
	import act_pkg::*;
(
	input wire logic [5:0] chan_i,
	input wire logic ext_mux_en_i,
	output act_sel_t sel_o
);
	wire logic is_low_bank = (chan_i[5:3] == 3'h0);
	wire logic is_hi_ext = (chan_i[5:3] == 3'h2);
	wire logic [3:0] direct_pin = {2'h0, chan_i[1:0]};
	wire logic [3:0] ext_pin = {2'h0, chan_i[4], chan_i[0]};
	wire logic ext_ok = is_low_bank || is_hi_ext;
	wire logic dir_ok = is_low_bank && (chan_i[2] == 1'b0);
	logic [3:0] pin;
	act_ref_t ref_sel;

	always_comb
	begin
		pin = ACT_PIN_NONE;
		ref_sel = ACT_REF_NONE;
		if (chan_i == ACT_CH_REF_LO)
			ref_sel = ACT_REF_LOW;
		else if (chan_i == ACT_CH_REF_HI)
			ref_sel = ACT_REF_HIGH;
		else if (chan_i == ACT_CH_MID)
			ref_sel = ACT_REF_MID;
		else if (chan_i == ACT_CH_AN55)
			pin = ACT_PIN_AN55;
		else if (chan_i == ACT_CH_AN56)
			pin = ACT_PIN_AN56;
		else if (!ext_mux_en_i && chan_i == ACT_CH_ADR0)
			pin = ACT_PIN_ADR0;
		else if (!ext_mux_en_i && chan_i == ACT_CH_ADR1)
			pin = ACT_PIN_ADR1;
		else if (ext_mux_en_i && ext_ok)
			pin = ext_pin;
		else if (!ext_mux_en_i && dir_ok)
			pin = direct_pin;
	end

	assign sel_o.pin = pin;
	assign sel_o.ref_sel = ref_sel;
	assign sel_o.ext_mux_addr_out = chan_i[2:1];
	assign sel_o.valid = (pin != ACT_PIN_NONE) || (ref_sel != ACT_REF_NONE);
endmodule

/* design/act_conv_timing.sv */
// Conversion timing engine: sample phases, successive approximation, EOC.
// Assumes queue control holds the command entry stable from the launch
// strobe until end of conversion, and conv_clock is a one-cycle enable.
`timescale 1ns/100ps
module act_conv_timing
	import act_pkg::*;
#(
	parameter int RES_BITS = ACT_RES_BITS
)
(
	input wire logic SYS_CLK_I,
	input wire logic RESET_N_I,
	input wire logic CONV_CLOCK_I,
	input wire logic STOP_I,
	input wire logic EXT_MUX_EN_I,
	input wire logic [1:0] PORT_A_DIRECTION_BITS_I,
	input wire logic [1:0] PORT_A_DATA_I,
	input wire act_cmd_t COMMAND_ENTRY_I,
	input wire logic CONV_LAUNCH_STROBE_I,
	input wire logic COMPARATOR_I,
	output act_sel_t SEL_O,
	output logic [1:0] PORT_A_OE_N_O,
	output logic [1:0] PORT_A_OUT_O,
	output logic BIAS_ON_O,
	output logic BUF_AMP_EN_O,
	output logic SAMPLE_O,
	output logic [RES_BITS-1:0] DAC_TRIAL_O,
	output logic BUSY_O,
	output logic EOC_O,
	output logic [RES_BITS-1:0] RESULT_O
);
	typedef enum logic [1:0]
	{
		ACT_IDLE,
		ACT_INIT,
		ACT_FINAL,
		ACT_RESOLVE
	} act_state_t;

	act_state_t state_r;
	act_state_t state_nxt;
	logic [4:0] cnt_r;
	logic [4:0] cnt_nxt;
	logic [RES_BITS-1:0] sar_r;
	logic [RES_BITS-1:0] sar_nxt;
	logic [RES_BITS-1:0] bit_r;
	logic [RES_BITS-1:0] bit_nxt;
	logic [RES_BITS-1:0] result_r;
	logic [RES_BITS-1:0] result_nxt;
	logic eoc_r;
	logic eoc_nxt;
	logic [1:0] addr_r;
	logic [1:0] addr_nxt;
	act_sel_t dec_sel;

	act_chan_decode u_dec
	(
		.chan_i(COMMAND_ENTRY_I.chan),
		.ext_mux_en_i(EXT_MUX_EN_I),
		.sel_o(dec_sel)
	);

	localparam logic [4:0] INIT_LAST = 5'(ACT_INIT_SAMPLE_CYC - 1);
	localparam logic [4:0] FINAL_MIN = 5'(ACT_FINAL_MIN_CYC);
	wire logic [4:0] final_last =
		5'((FINAL_MIN << COMMAND_ENTRY_I.final_sample_sel) - 5'h1);
	wire logic tick = CONV_CLOCK_I && !STOP_I;
	wire logic init_done = tick && (cnt_r == INIT_LAST);
	wire logic final_done = tick && (cnt_r == final_last);
	wire logic res_done = tick && bit_r[0];
	wire logic [RES_BITS-1:0] sar_kept =
		COMPARATOR_I ? sar_r : (sar_r & ~bit_r);

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		sar_nxt = sar_r;
		bit_nxt = bit_r;
		result_nxt = result_r;
		eoc_nxt = 1'b0;
		addr_nxt = addr_r;
		case (state_r)
			ACT_IDLE:
			begin
				if (CONV_LAUNCH_STROBE_I && !STOP_I)
				begin
					addr_nxt = dec_sel.ext_mux_addr_out;
					cnt_nxt = 5'h0;
					if (COMMAND_ENTRY_I.buffer_skip_flag)
						state_nxt = ACT_FINAL;
					else
						state_nxt = ACT_INIT;
				end
			end
			ACT_INIT:
			begin
				if (tick)
					cnt_nxt = 5'(cnt_r + 5'h1);
				if (init_done)
				begin
					cnt_nxt = 5'h0;
					state_nxt = ACT_FINAL;
				end
			end
			ACT_FINAL:
			begin
				if (tick)
					cnt_nxt = 5'(cnt_r + 5'h1);
				if (final_done)
				begin
					state_nxt = ACT_RESOLVE;
					bit_nxt = {1'b1, {(RES_BITS-1){1'b0}}};
					sar_nxt = {1'b1, {(RES_BITS-1){1'b0}}};
				end
			end
			ACT_RESOLVE:
			begin
				if (tick)
				begin
					bit_nxt = bit_r >> 1;
					sar_nxt = sar_kept | (bit_r >> 1);
				end
				if (res_done)
				begin
					result_nxt = sar_kept;
					eoc_nxt = 1'b1;
					state_nxt = ACT_IDLE;
				end
			end
			default:
				state_nxt = ACT_IDLE;
		endcase
		if (STOP_I)
			state_nxt = ACT_IDLE;
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			state_r <= ACT_IDLE;
			cnt_r <= 5'h0;
			sar_r <= '0;
			bit_r <= '0;
			result_r <= '0;
			eoc_r <= 1'b0;
			addr_r <= 2'h0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			sar_r <= sar_nxt;
			bit_r <= bit_nxt;
			result_r <= result_nxt;
			eoc_r <= eoc_nxt;
			addr_r <= addr_nxt;
		end
	end

	assign SEL_O = '{pin: dec_sel.pin, ref_sel: dec_sel.ref_sel,
		ext_mux_addr_out: addr_r, valid: dec_sel.valid};
	// Address pins: outputs in mux mode regardless of direction bits
	assign PORT_A_OE_N_O =
		EXT_MUX_EN_I ? 2'h0 : ~PORT_A_DIRECTION_BITS_I;
	assign PORT_A_OUT_O = EXT_MUX_EN_I ? addr_r : PORT_A_DATA_I;
	assign BIAS_ON_O = !STOP_I;
	assign BUF_AMP_EN_O = (state_r == ACT_INIT);
	assign SAMPLE_O = (state_r == ACT_INIT) || (state_r == ACT_FINAL);
	assign DAC_TRIAL_O = sar_r;
	assign BUSY_O = (state_r != ACT_IDLE);
	assign EOC_O = eoc_r;
	assign RESULT_O = result_r;

	sequence act_launch_s;
		state_r == ACT_IDLE && CONV_LAUNCH_STROBE_I && !STOP_I;
	endsequence

	sequence act_resolve_end_s;
		state_r == ACT_RESOLVE && res_done && !STOP_I;
	endsequence

	AST_EOC_PULSE: assert property (@(posedge SYS_CLK_I)
		disable iff (!RESET_N_I) EOC_O |=> !EOC_O)
		else $error("End of conversion longer than one cycle");
	AST_SKIP_INIT: assert property (@(posedge SYS_CLK_I)
		disable iff (!RESET_N_I)
		act_launch_s ##0 COMMAND_ENTRY_I.buffer_skip_flag
		|=> state_r == ACT_FINAL)
		else $error("Bypass did not skip initial sample");
	AST_INIT_START: assert property (@(posedge SYS_CLK_I)
		disable iff (!RESET_N_I)
		act_launch_s ##0 !COMMAND_ENTRY_I.buffer_skip_flag
		|=> BUF_AMP_EN_O)
		else $error("Initial sample did not start");
	AST_INIT_LEN: assert property (@(posedge SYS_CLK_I)
		disable iff (!RESET_N_I) (state_r == ACT_INIT && init_done)
		|=> state_r == ACT_FINAL && !BUF_AMP_EN_O)
		else $error("Initial sample length wrong");
	AST_INIT_CNT: assert property (@(posedge SYS_CLK_I)
		disable iff (!RESET_N_I) state_r == ACT_INIT |-> cnt_r <= INIT_LAST)
		else $error("Initial sample overran");
	AST_FINAL_CNT: assert property (@(posedge SYS_CLK_I)
		disable iff (!RESET_N_I)
		state_r == ACT_FINAL |-> cnt_r <= final_last)
		else $error("Final sample overran");
	AST_MSB_FIRST: assert property (@(posedge SYS_CLK_I)
		disable iff (!RESET_N_I)
		(state_r == ACT_FINAL && final_done && !STOP_I)
		|=> bit_r[RES_BITS-1] && state_r == ACT_RESOLVE)
		else $error("Resolution did not start at MSB");
	AST_RESULT: assert property (@(posedge SYS_CLK_I)
		disable iff (!RESET_N_I) act_resolve_end_s
		|=> EOC_O && RESULT_O == $past(sar_kept))
		else $error("Result not transferred with end of conversion");
	AST_MUX_OUT: assert property (@(posedge SYS_CLK_I)
		disable iff (!RESET_N_I) EXT_MUX_EN_I
		|-> PORT_A_OE_N_O == 2'h0 && PORT_A_OUT_O == addr_r)
		else $error("Address pins not driven in mux mode");
	// Bias follows stop in the same cycle; the abort shows one cycle later
	AST_STOP: assert property (@(posedge SYS_CLK_I)
		disable iff (!RESET_N_I) STOP_I |-> !BIAS_ON_O ##1 !BUSY_O)
		else $error("Stop did not halt conversion");
endmodule

/* tb/act_analog_model.sv */
// Far side model: four external muxes, input pins, references, comparator.
// Assumes the front end selection stays put for the whole conversion.
`timescale 1ns/100ps
module act_analog_model
	import act_pkg::*;
(
	input wire act_sel_t sel_i,
	input wire logic ext_mux_en_i,
	input wire logic [9:0] trial_i,
	output logic comparator_o
);
	logic [1:0] addr;
	logic [9:0] level;
	// Only the four group inputs sit behind a mux chip
	assign addr = (ext_mux_en_i && sel_i.pin < 4'h4) ?
		sel_i.ext_mux_addr_out : 2'h0;
	assign level = (sel_i.ref_sel == ACT_REF_LOW) ? 10'h000 :
		(sel_i.ref_sel == ACT_REF_HIGH) ? 10'h3FF :
		(sel_i.ref_sel == ACT_REF_MID) ? 10'h200 :
		{sel_i.pin, addr, 4'h9};
	assign comparator_o = (level >= trial_i);
endmodule

/* tb/tb_act_conv_timing.sv */
// Testbench for the conversion timing and channel selection block.
// Assumes a converter clock enable of one tick every four system clocks.
`timescale 1ns/100ps
module tb_act_conv_timing
	import act_pkg::*;
;
	logic clk = 1'b0, rst_n = 1'b0, conv = 1'b0, stop = 1'b0, mux = 1'b0;
	logic strobe = 1'b0, comp, bias, buf_en, samp, busy, eoc;
	logic [1:0] dir = 2'h1, pdat = 2'h2, oe_n, pout, div = 2'h0;
	logic [9:0] trial, result;
	act_cmd_t cmd = '0;
	act_sel_t sel;
	int fails = 0, checked = 0;

	act_conv_timing uut (.SYS_CLK_I(clk), .RESET_N_I(rst_n),
		.CONV_CLOCK_I(conv), .STOP_I(stop), .EXT_MUX_EN_I(mux),
		.PORT_A_DIRECTION_BITS_I(dir), .PORT_A_DATA_I(pdat),
		.COMMAND_ENTRY_I(cmd), .CONV_LAUNCH_STROBE_I(strobe),
		.COMPARATOR_I(comp), .SEL_O(sel), .PORT_A_OE_N_O(oe_n),
		.PORT_A_OUT_O(pout), .BIAS_ON_O(bias), .BUF_AMP_EN_O(buf_en),
		.SAMPLE_O(samp), .DAC_TRIAL_O(trial), .BUSY_O(busy), .EOC_O(eoc),
		.RESULT_O(result));
	act_analog_model far (.sel_i(sel), .ext_mux_en_i(mux),
		.trial_i(trial), .comparator_o(comp));

	initial
	begin
		forever #20 clk = ~clk;
	end

	always @(posedge clk)
	begin
		div <= div + 2'h1;
		// Slow converter clock, so short bypassed samples are acceptable
		conv <= (div == 2'h3);
	end

	task automatic close_out();
		if (fails == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [9:0] e,
		input logic [9:0] g);
		checked++;
		if (g !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic launch(input logic [5:0] ch, input logic [1:0] fs,
		input logic skip);
		@(posedge clk);
		cmd <= '{ch, fs, skip};
		strobe <= 1'b1;
		@(posedge clk);
		strobe <= 1'b0;
		#1;
	endtask

	// One conversion, timed in converter ticks and judged at its end
	task automatic run(input logic [5:0] ch, input logic [1:0] fs,
		input logic skip, input logic mx, input logic [3:0] pin,
		input logic [9:0] lvl);
		int ticks;
		int want;
		logic amp;
		logic smp;
		ticks = 0;
		want = (skip ? 0 : ACT_INIT_SAMPLE_CYC) + (ACT_FINAL_MIN_CYC << fs);
		want += ACT_RES_BITS;
		amp = 1'b0;
		smp = 1'b0;
		@(posedge clk);
		mux <= mx;
		dir <= mx ? 2'h0 : 2'h1;
		launch(ch, fs, skip);
		chk("busy_start", 10'h001, 10'(busy));
		repeat (200)
		begin
			if (eoc === 1'b1)
				break;
			ticks += int'(conv);
			amp |= buf_en;
			smp |= samp;
			@(posedge clk);
			#1;
		end
		if (eoc !== 1'b1)
		begin
			fails++;
			close_out();
		end
		chk("ticks", 10'(want), 10'(ticks));
		chk("buf_amp", 10'(!skip), 10'(amp));
		chk("sample", 10'h001, 10'(smp));
		chk("result", lvl, result);
		chk("pin", 10'(pin), 10'(sel.pin));
		chk("valid", 10'h001, 10'(sel.valid));
		chk("busy", 10'h000, 10'(busy));
		if (mx)
		begin
			chk("mux_addr", 10'(ch[2:1]), 10'(sel.ext_mux_addr_out));
			chk("pin_out", 10'(ch[2:1]), 10'(pout));
			chk("oe_n", 10'h000, 10'(oe_n));
		end
		else
		begin
			chk("oe_n", 10'h002, 10'(oe_n));
			chk("pin_out", 10'(pdat), 10'(pout));
		end
		@(posedge clk);
		#1;
		chk("eoc_pulse", 10'h000, 10'(eoc));
	endtask

	task automatic stop_abort();
		logic seen;
		seen = 1'b0;
		launch(6'h01, 2'h3, 1'b0);
		repeat (20) @(posedge clk);
		stop <= 1'b1;
		launch(6'h02, 2'h0, 1'b0);
		repeat (60)
		begin
			@(posedge clk);
			#1;
			seen |= eoc;
		end
		chk("bias_off", 10'h000, 10'(bias));
		chk("abort_busy", 10'h000, 10'(busy));
		chk("abort_eoc", 10'h000, 10'(seen));
		@(posedge clk);
		stop <= 1'b0;
		#1;
		chk("bias_on", 10'h001, 10'(bias));
	endtask

	// Channels that select no input in the current mode
	task automatic chan_reject();
		@(posedge clk);
		mux <= 1'b1;
		cmd <= '{6'h34, 2'h0, 1'b0};
		@(posedge clk);
		#1;
		chk("adr_pin", 10'h00F, 10'(sel.pin));
		chk("adr_valid", 10'h000, 10'(sel.valid));
		@(posedge clk);
		mux <= 1'b0;
		cmd <= '{6'h05, 2'h0, 1'b0};
		@(posedge clk);
		#1;
		chk("dir_pin", 10'h00F, 10'(sel.pin));
		chk("dir_valid", 10'h000, 10'(sel.valid));
	endtask

	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk("reset_result", 10'h000, result);
		chk("reset_busy", 10'h000, 10'(busy));
		for (int f = 0; f < 4; f++)
			for (int b = 0; b < 2; b++)
				run(6'h01, 2'(f), 1'(b), 1'b0, 4'h1, 10'h049);
		run(6'h06, 2'h2, 1'b0, 1'b1, 4'h0, 10'h039);
		run(6'h17, 2'h0, 1'b0, 1'b1, 4'h3, 10'h0F9);
		run(6'h13, 2'h1, 1'b1, 1'b1, 4'h3, 10'h0D9);
		run(6'h04, 2'h0, 1'b0, 1'b1, 4'h0, 10'h029);
		run(6'h34, 2'h0, 1'b0, 1'b0, 4'h4, 10'h109);
		run(6'h35, 2'h0, 1'b0, 1'b0, 4'h5, 10'h149);
		run(6'h37, 2'h0, 1'b0, 1'b1, 4'h6, 10'h189);
		run(6'h38, 2'h0, 1'b0, 1'b0, 4'h7, 10'h1C9);
		run(6'h3C, 2'h0, 1'b0, 1'b0, 4'hF, 10'h000);
		run(6'h3D, 2'h0, 1'b0, 1'b0, 4'hF, 10'h3FF);
		run(6'h3E, 2'h0, 1'b0, 1'b0, 4'hF, 10'h200);
		stop_abort();
		chan_reject();
		close_out();
	end
endmodule
